// >>> rtl/hci_int_status.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - B pool ready after reset or empty pool
// - B pool ready per freed pool, no end
// - B after end: ready when frame out
// - B message repeat sets extended flag
// - B underrun when drained before end
// - D status read clears unmasked bits but C/I
// - D extended read clears it and summary
// - D mask hides bit, event kept pending
// - Read under mask leaves pending untouched
// - Top mask blocks extended summary, interrupt
// - C/I sets bit even masked, no interrupt
// - D causes visible in status, extended registers
// - Pool full; host reads 32, sends complete
// - Message end flagged; host acknowledges complete
// - D overflow when whole frame lost
// - Protocol error in automatic mode only
// - D pool ready when FIFO accepts data
// - Auto info-frame end: ready only after peer ack
// - Repeat on error or auto-mode nack
// - D underrun aborts frame before end
// - Auto mode peer ready/not-ready status change
// - Timer flag: external, or auto-mode T200 with N200
// - Timer 2 flag, no special acknowledge
// - Interrupt low while unmasked source pending
// - Top bits 5-0 summarise lower registers
module hci_int_status (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire hci_pkg::hci_b_ev_t [1:0] bEv,
  input wire hci_pkg::hci_d_ev_t dEv,
  output logic [1:0] bTxAbort,
  output logic dTxAbort,
  output logic dRxMsgComplete,
  output logic intN
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic wrTopMask, wrDMask, wrDCmd, wrDMode, rdDStat, rdDExt, rdCi;
  logic [1:0] wrBMask, wrBCmd, rdBStat, rdBExt;

  always_comb begin
    wrTopMask = regWr && (regAddr == hci_pkg::TOP_MASK_ADDR);
    wrDMask = regWr && (regAddr == hci_pkg::D_MASK_ADDR);
    wrDCmd = regWr && (regAddr == hci_pkg::D_CMD_ADDR);
    wrDMode = regWr && (regAddr == hci_pkg::D_MODE_ADDR);
    rdDStat = regRd && (regAddr == hci_pkg::D_STAT_ADDR);
    rdDExt = regRd && (regAddr == hci_pkg::D_EXT_ADDR);
    rdCi = regRd && (regAddr == hci_pkg::CI_RX_ADDR);
    for (int i = 0; i < 2; i++) begin
      logic pageHit;
      pageHit = regAddr[7:4] == 4'(hci_pkg::B_PAGE_A + 4'(i));
      wrBMask[i] = regWr && pageHit && (regAddr[3:0] == hci_pkg::B_MASK_OFS);
      wrBCmd[i] = regWr && pageHit && (regAddr[3:0] == hci_pkg::B_CMD_OFS);
      rdBStat[i] = regRd && pageHit && (regAddr[3:0] == hci_pkg::B_STAT_OFS);
      rdBExt[i] = regRd && pageHit && (regAddr[3:0] == hci_pkg::B_EXT_OFS);
    end
  end

  // ----------------------------------------
  // B channel transmit sequencing
  // ----------------------------------------
  hci_pkg::hci_tx_state_t [1:0] bState_q, bState_d;
  logic [1:0] bSetXpr, bSetXdu, bAbort_d;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      logic setXpr;
      logic setXdu;
      logic transmitter_reset_cmd;
      logic transparent_frame_send_cmd;
      logic message_end_cmd;
      setXpr = 1'b0;
      setXdu = 1'b0;
      transmitter_reset_cmd = wrBCmd[i] && regWdata[hci_pkg::CMD_TRANSMITTER_RESET_CMD];
      transparent_frame_send_cmd = wrBCmd[i] && regWdata[hci_pkg::CMD_XTF];
      message_end_cmd = wrBCmd[i] && regWdata[hci_pkg::CMD_XME];
      bState_d[i] = bState_q[i];
      bAbort_d[i] = 1'b0;
      if (transmitter_reset_cmd) begin
        bState_d[i] = hci_pkg::TX_IDLE;
        setXpr = 1'b1;
      end else begin
        case (bState_q[i])
          hci_pkg::TX_IDLE: begin
            if (transparent_frame_send_cmd) begin
              bState_d[i] = message_end_cmd ? hci_pkg::TX_EOM : hci_pkg::TX_SEND;
            end
          end
          hci_pkg::TX_SEND: begin
            if (message_end_cmd) begin
              bState_d[i] = hci_pkg::TX_EOM;
            end else if (bEv[i].fifoDrained) begin
              setXdu = 1'b1;
              bAbort_d[i] = 1'b1;
              bState_d[i] = hci_pkg::TX_IDLE;
            end else if (bEv[i].poolFreed) begin
              setXpr = 1'b1;
            end
          end
          hci_pkg::TX_EOM: begin
            // Pool frees while closing are not reported
            if (bEv[i].frameDone) begin
              setXpr = 1'b1;
              bState_d[i] = hci_pkg::TX_IDLE;
            end
          end
          default: begin
            bState_d[i] = hci_pkg::TX_IDLE;
          end
        endcase
      end
      bSetXpr[i] = setXpr;
      bSetXdu[i] = setXdu;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bState_q[0] <= hci_pkg::TX_IDLE;
      bState_q[1] <= hci_pkg::TX_IDLE;
      bTxAbort <= 2'h0;
    end else begin
      bState_q <= bState_d;
      bTxAbort <= bAbort_d;
    end
  end

  // ----------------------------------------
  // B channel status, mask, extended
  // ----------------------------------------
  logic [1:0] bXpr_q, bXpr_d, bXmr_q, bXmr_d, bXdu_q, bXdu_d;
  logic [1:0] bMask_q, bMask_d, bVis;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      bMask_d[i] = wrBMask[i] ? regWdata[hci_pkg::B_XPR] : bMask_q[i];
      // Masked flag survives the read, so it shows once unmasked
      bXpr_d[i] = bSetXpr[i] || (bXpr_q[i] && !(rdBStat[i] && !bMask_q[i]));
      bXmr_d[i] = bEv[i].repeatReq || (bXmr_q[i] && !rdBExt[i]);
      bXdu_d[i] = bSetXdu[i] || (bXdu_q[i] && !rdBExt[i]);
      bVis[i] = bXpr_q[i] && !bMask_q[i];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bXpr_q <= 2'h0;
      bXmr_q <= 2'h0;
      bXdu_q <= 2'h0;
      bMask_q <= 2'h0;
    end else begin
      bXpr_q <= bXpr_d;
      bXmr_q <= bXmr_d;
      bXdu_q <= bXdu_d;
      bMask_q <= bMask_d;
    end
  end

  // ----------------------------------------
  // D channel transmit sequencing
  // ----------------------------------------
  hci_pkg::hci_tx_state_t dState_q, dState_d;
  logic [7:0] dMode_q, dMode_d;
  logic autoMode, dSetXpr, dSetXdu, dAbort_d, dRmc_d;

  always_comb begin
    logic transmitter_reset_cmd;
    logic transparent_frame_send_cmd;
    logic info_frame_send_cmd;
    logic message_end_cmd;
    transmitter_reset_cmd = wrDCmd && regWdata[hci_pkg::CMD_TRANSMITTER_RESET_CMD];
    transparent_frame_send_cmd = wrDCmd && regWdata[hci_pkg::CMD_XTF];
    info_frame_send_cmd = wrDCmd && regWdata[hci_pkg::CMD_XIF];
    message_end_cmd = wrDCmd && regWdata[hci_pkg::CMD_XME];
    // Only bit 0 steers the logic; the other mode bits read back as written
    autoMode = dMode_q[hci_pkg::MODE_AUTO];
    dMode_d = wrDMode ? regWdata : dMode_q;
    dRmc_d = wrDCmd && regWdata[hci_pkg::CMD_RMC];
    dState_d = dState_q;
    dSetXpr = 1'b0;
    dSetXdu = 1'b0;
    dAbort_d = 1'b0;
    if (transmitter_reset_cmd) begin
      dState_d = hci_pkg::TX_IDLE;
      dSetXpr = 1'b1;
    end else begin
      case (dState_q)
        hci_pkg::TX_IDLE: begin
          if (transparent_frame_send_cmd || info_frame_send_cmd) begin
            dState_d = message_end_cmd ? ((info_frame_send_cmd && autoMode) ? hci_pkg::TX_ACKW : hci_pkg::TX_EOM) : hci_pkg::TX_SEND;
          end
        end
        hci_pkg::TX_SEND: begin
          if (message_end_cmd) begin
            dState_d = (info_frame_send_cmd && autoMode) ? hci_pkg::TX_ACKW : hci_pkg::TX_EOM;
          end else if (dEv.fifoDrained) begin
            dSetXdu = 1'b1;
            dAbort_d = 1'b1;
            dState_d = hci_pkg::TX_IDLE;
          end else if (dEv.poolFreed) begin
            dSetXpr = 1'b1;
          end
        end
        hci_pkg::TX_EOM: begin
          if (dEv.frameDone) begin
            dSetXpr = 1'b1;
            dState_d = hci_pkg::TX_IDLE;
          end
        end
        hci_pkg::TX_ACKW: begin
          // Frame fully sent is not enough; the peer must confirm it
          if (dEv.peerAck) begin
            dSetXpr = 1'b1;
            dState_d = hci_pkg::TX_IDLE;
          end
        end
        default: begin
          dState_d = hci_pkg::TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dState_q <= hci_pkg::TX_IDLE;
      dMode_q <= hci_pkg::MODE_RST;
      dTxAbort <= 1'b0;
      dRxMsgComplete <= 1'b0;
    end else begin
      dState_q <= dState_d;
      dMode_q <= dMode_d;
      dTxAbort <= dAbort_d;
      dRxMsgComplete <= dRmc_d;
    end
  end

  // ----------------------------------------
  // D channel status, mask, extended
  // ----------------------------------------
  logic [7:0] dStat_q, dStat_d, dExt_q, dExt_d, dMask_q, dMask_d;
  logic [7:0] dSet, extSet, dClr, dVis;
  logic [3:0] ciCode_q, ciCode_d;

  always_comb begin
    dSet = 8'h00;
    dSet[hci_pkg::D_RPF] = dEv.rxPoolFull;
    dSet[hci_pkg::D_RME] = dEv.rxMsgEnd;
    dSet[hci_pkg::D_XPR] = dSetXpr;
    dSet[hci_pkg::D_RSC] = autoMode && dEv.peerStatus;
    dSet[hci_pkg::D_TIN] = dEv.extTimer || (autoMode && dEv.t200Expired && dEv.n200Expired);
    dSet[hci_pkg::D_SECOND_TIMER_EXPIRED_FLAG] = dEv.timer2;
    dSet[hci_pkg::D_CIC] = dEv.ciChange;
    dSet[hci_pkg::D_MOS] = dEv.monStatus;
    extSet = 8'h00;
    extSet[hci_pkg::EXT_RFO] = dEv.rxOverflow;
    extSet[hci_pkg::EXT_PCE] = autoMode && dEv.protoErr;
    extSet[hci_pkg::EXT_XDU] = dSetXdu;
    extSet[hci_pkg::EXT_XMR] = dEv.txError || (autoMode && dEv.peerNack);
    // Read clears only the unmasked bits; C/I clears via its own register
    dClr = rdDStat ? ~dMask_q : 8'h00;
    dClr[hci_pkg::D_CIC] = rdCi;
    dStat_d = dSet | (dStat_q & ~dClr);
    dExt_d = extSet | (dExt_q & ~(rdDExt ? 8'hFF : 8'h00));
    dMask_d = wrDMask ? regWdata : dMask_q;
    ciCode_d = dEv.ciChange ? dEv.ciCode : ciCode_q;
    dVis = dStat_q & ~dMask_q;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dStat_q <= hci_pkg::STAT_RST;
      dExt_q <= hci_pkg::STAT_RST;
      dMask_q <= hci_pkg::MASK_RST;
      ciCode_q <= hci_pkg::CI_RST;
    end else begin
      dStat_q <= dStat_d;
      dExt_q <= dExt_d;
      dMask_q <= dMask_d;
      ciCode_q <= ciCode_d;
    end
  end

  // ----------------------------------------
  // Top-level summary and interrupt
  // ----------------------------------------
  logic [7:0] topMask_q, topMask_d, topSrc, topVis;
  logic intN_d;

  always_comb begin
    topSrc = 8'h00;
    // Summaries are live ORs, so acknowledging a source clears them without a top read
    topSrc[hci_pkg::TOP_IDC] = |dVis;
    topSrc[hci_pkg::TOP_EXD] = |dExt_q;
    topSrc[hci_pkg::TOP_ICA] = bVis[0];
    topSrc[hci_pkg::TOP_EXA] = bXmr_q[0] || bXdu_q[0];
    topSrc[hci_pkg::TOP_ICB] = bVis[1];
    topSrc[hci_pkg::TOP_EXB] = bXmr_q[1] || bXdu_q[1];
    topVis = topSrc & ~topMask_q;
    topMask_d = wrTopMask ? regWdata : topMask_q;
    // Level output: stays low until every unmasked source is read away
    intN_d = ~|topVis;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      topMask_q <= hci_pkg::MASK_RST;
      intN <= 1'b1;
    end else begin
      topMask_q <= topMask_d;
      intN <= intN_d;
    end
  end

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  logic [7:0] rdata_d;
  // Idle slots return zero so a stray sample reads nothing

  always_comb begin
    rdata_d = 8'h00;
    if (!regRd) begin
      rdata_d = 8'h00;
    end else if (regAddr == hci_pkg::TOP_STAT_ADDR) begin
      rdata_d = topVis;
    end else if (regAddr == hci_pkg::TOP_MASK_ADDR) begin
      rdata_d = topMask_q;
    end else if (regAddr == hci_pkg::D_STAT_ADDR) begin
      rdata_d = dVis;
      rdata_d[hci_pkg::D_CIC] = dStat_q[hci_pkg::D_CIC];
    end else if (regAddr == hci_pkg::D_MASK_ADDR) begin
      rdata_d = dMask_q;
    end else if (regAddr == hci_pkg::D_EXT_ADDR) begin
      rdata_d = dExt_q;
    end else if (regAddr == hci_pkg::D_MODE_ADDR) begin
      rdata_d = dMode_q;
    end else if (regAddr == hci_pkg::CI_RX_ADDR) begin
      rdata_d = {3'h0, dStat_q[hci_pkg::D_CIC], ciCode_q};
    end else if (rdBStat[0]) begin
      rdata_d[hci_pkg::B_XPR] = bVis[0];
    end else if (rdBStat[1]) begin
      rdata_d[hci_pkg::B_XPR] = bVis[1];
    end else if (rdBExt[0]) begin
      rdata_d[hci_pkg::EXT_XMR] = bXmr_q[0];
      rdata_d[hci_pkg::EXT_XDU] = bXdu_q[0];
    end else if (rdBExt[1]) begin
      rdata_d[hci_pkg::EXT_XMR] = bXmr_q[1];
      rdata_d[hci_pkg::EXT_XDU] = bXdu_q[1];
    end else if (regAddr[7:4] == hci_pkg::B_PAGE_A && regAddr[3:0] == hci_pkg::B_MASK_OFS) begin
      rdata_d[hci_pkg::B_XPR] = bMask_q[0];
    end else if (regAddr[7:4] == 4'(hci_pkg::B_PAGE_A + 4'h1) && regAddr[3:0] == hci_pkg::B_MASK_OFS) begin
      rdata_d[hci_pkg::B_XPR] = bMask_q[1];
    end else begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// >>> shared/hci_pkg.sv
package hci_pkg;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] TOP_STAT_ADDR = 8'h00;
  localparam logic [7:0] TOP_MASK_ADDR = 8'h01;
  localparam logic [7:0] D_STAT_ADDR = 8'h02;
  localparam logic [7:0] D_MASK_ADDR = 8'h03;
  localparam logic [7:0] D_EXT_ADDR = 8'h04;
  localparam logic [7:0] D_CMD_ADDR = 8'h05;
  localparam logic [7:0] D_MODE_ADDR = 8'h06;
  localparam logic [7:0] CI_RX_ADDR = 8'h07;

  // B channel A sits in page 1, channel B in page 2
  localparam logic [3:0] B_PAGE_A = 4'h1;
  localparam logic [3:0] B_STAT_OFS = 4'h0;
  localparam logic [3:0] B_MASK_OFS = 4'h1;
  localparam logic [3:0] B_EXT_OFS = 4'h2;
  localparam logic [3:0] B_CMD_OFS = 4'h3;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TOP_EXB = 0;
  localparam int TOP_ICB = 1;
  localparam int TOP_EXA = 2;
  localparam int TOP_ICA = 3;
  localparam int TOP_EXD = 4;
  localparam int TOP_IDC = 5;

  localparam int D_SECOND_TIMER_EXPIRED_FLAG = 0;
  localparam int D_MOS = 1;
  localparam int D_CIC = 2;
  localparam int D_TIN = 3;
  localparam int D_XPR = 4;
  localparam int D_RSC = 5;
  localparam int D_RPF = 6;
  localparam int D_RME = 7;

  localparam int EXT_RFO = 4;
  localparam int EXT_PCE = 5;
  localparam int EXT_XDU = 6;
  localparam int EXT_XMR = 7;

  localparam int B_XPR = 4;

  localparam int CMD_TRANSMITTER_RESET_CMD = 0;
  localparam int CMD_XTF = 1;
  localparam int CMD_XIF = 2;
  localparam int CMD_XME = 3;
  localparam int CMD_RMC = 4;

  localparam int MODE_AUTO = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [3:0] CI_RST = 4'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_EOM = 2'b11,
    TX_ACKW = 2'b10
  } hci_tx_state_t;

  typedef struct packed {
    logic poolFreed;
    logic frameDone;
    logic fifoDrained;
    logic repeatReq;
  } hci_b_ev_t;

  typedef struct packed {
    logic rxPoolFull;
    logic rxMsgEnd;
    logic rxOverflow;
    logic protoErr;
    logic poolFreed;
    logic frameDone;
    logic peerAck;
    logic fifoDrained;
    logic txError;
    logic peerNack;
    logic peerStatus;
    logic extTimer;
    logic t200Expired;
    logic n200Expired;
    logic timer2;
    logic ciChange;
    logic [3:0] ciCode;
    logic monStatus;
  } hci_d_ev_t;

endpackage

// >>> testbench/hci_int_status_properties.sv
`timescale 1ns/1ps
`default_nettype none
module hci_int_status_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire hci_pkg::hci_b_ev_t [1:0] bEv,
  input wire hci_pkg::hci_d_ev_t dEv,
  input wire logic [1:0] bTxAbort,
  input wire logic dTxAbort,
  input wire logic dRxMsgComplete,
  input wire logic intN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_rmcCmd;
    regWr && regAddr == hci_pkg::D_CMD_ADDR && regWdata[hci_pkg::CMD_RMC];
  endsequence
  // Flag then interrupt register give two or three cycles of lag
  sequence s_setCause;
    $past(regWr || (|bEv) || (|dEv), 2) || $past(regWr || (|bEv) || (|dEv), 3);
  endsequence
  sequence s_clrCause;
    $past(regWr || regRd, 2) || $past(regWr || regRd, 3);
  endsequence
  property p_rdIdle;
    regRdata != 8'h00 |-> $past(regRd);
  endproperty
  property p_rmc;
    s_rmcCmd |=> dRxMsgComplete;
  endproperty
  property p_rmcCause;
    dRxMsgComplete |-> $past(regWr && regAddr == hci_pkg::D_CMD_ADDR && regWdata[hci_pkg::CMD_RMC]);
  endproperty
  property p_dAbort;
    dTxAbort |-> $past(dEv.fifoDrained);
  endproperty
  property p_bAbortA;
    bTxAbort[0] |-> $past(bEv[0].fifoDrained);
  endproperty
  property p_bAbortB;
    bTxAbort[1] |-> $past(bEv[1].fifoDrained);
  endproperty
  property p_intFall;
    $fell(intN) |-> s_setCause;
  endproperty
  property p_intRise;
    $rose(intN) |-> s_clrCause;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
  a_rmc: assert property (p_rmc) else $error("no receive complete pulse");
  a_rmcCause: assert property (p_rmcCause) else $error("stray receive complete");
  a_dAbort: assert property (p_dAbort) else $error("stray D abort");
  a_bAbortA: assert property (p_bAbortA) else $error("stray B abort A");
  a_bAbortB: assert property (p_bAbortB) else $error("stray B abort B");
  a_intFall: assert property (p_intFall) else $error("interrupt without cause");
  a_intRise: assert property (p_intRise) else $error("interrupt dropped without access");
endmodule

bind hci_int_status hci_int_status_properties u_props (
  .clk(clk),
  .resetn(resetn),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regWr(regWr),
  .regRd(regRd),
  .regRdata(regRdata),
  .bEv(bEv),
  .dEv(dEv),
  .bTxAbort(bTxAbort),
  .dTxAbort(dTxAbort),
  .dRxMsgComplete(dRxMsgComplete),
  .intN(intN)
);
`default_nettype wire

// >>> testbench/hci_host.sv
`timescale 1ns/1ps
`default_nettype none
module hci_host (
  input wire logic clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  output logic regWr,
  output logic regRd,
  input wire logic [7:0] regRdata
);
  // ----------------------------------------
  // Host bus cycles
  // ----------------------------------------
  initial begin
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // Idle edge after each strobe so no signal is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdata;
    @(posedge clk);
  endtask
  // Issued once the counted octets have been drained from the FIFO
  task automatic ack();
    wr(hci_pkg::D_CMD_ADDR, 8'h10);
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_hdlc_channel_interrupt_status.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hdlc_channel_interrupt_status;
  localparam logic [7:0] TS = hci_pkg::TOP_STAT_ADDR;
  localparam logic [7:0] TM = hci_pkg::TOP_MASK_ADDR;
  localparam logic [7:0] DS = hci_pkg::D_STAT_ADDR;
  localparam logic [7:0] DM = hci_pkg::D_MASK_ADDR;
  localparam logic [7:0] DX = hci_pkg::D_EXT_ADDR;
  localparam logic [7:0] DC = hci_pkg::D_CMD_ADDR;
  localparam logic [7:0] MD = hci_pkg::D_MODE_ADDR;
  localparam logic [7:0] CI = hci_pkg::CI_RX_ADDR;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr, regWdata, regRdata;
  logic regWr, regRd, dTxAbort, dRxMsgComplete, intN;
  logic [1:0] bTxAbort;
  hci_pkg::hci_b_ev_t [1:0] bEv = '0;
  hci_pkg::hci_d_ev_t dEv = '0;
  logic [3:0] pulseCnt = 4'h0;
  int num_errors = 0;
  int comparisons = 0;

  always #5 clk = ~clk;

  hci_host host (.clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  hci_int_status DUT (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .bEv(bEv), .dEv(dEv), .bTxAbort(bTxAbort), .dTxAbort(dTxAbort),
    .dRxMsgComplete(dRxMsgComplete), .intN(intN));

  always @(negedge clk) begin
    pulseCnt <= pulseCnt + 4'(dTxAbort) + 4'(bTxAbort[0]) + 4'(bTxAbort[1]) + 4'(dRxMsgComplete);
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask
  task automatic ev(input logic [20:0] d, input logic [7:0] b);
    dEv <= d;
    bEv <= b;
    @(posedge clk);
    dEv <= '0;
    bEv <= '0;
    repeat (3) @(posedge clk);
  endtask
  // Interrupt output lags its cause by up to three edges
  task automatic ci(input logic exp);
    repeat (3) @(negedge clk);
    chk("intN", {7'h00, intN}, {7'h00, exp});
    @(posedge clk);
  endtask
  task automatic results();
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #50000;
    num_errors++;
    results();
  end

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rc(TS, 8'h00);
    rc(DM, hci_pkg::MASK_RST);
    rc(MD, hci_pkg::MODE_RST);
    rc(8'hFF, 8'h00);
    ci(1'b1);
    host.wr(8'h13, 8'h01);
    ci(1'b0);
    rc(TS, 8'h08);
    rc(8'h10, 8'h10);
    rc(TS, 8'h00);
    ci(1'b1);
    rc(8'h10, 8'h00);
    host.wr(8'h23, 8'h02);
    ev(21'h000000, 8'h80);
    rc(8'h20, 8'h10);
    ev(21'h000000, 8'h20);
    rc(8'h22, 8'h40);
    rc(TS, 8'h00);
    host.wr(8'h13, 8'h0A);
    ev(21'h000000, 8'h08);
    ev(21'h000000, 8'h03);
    rc(8'h10, 8'h00);
    rc(8'h12, 8'h80);
    ev(21'h000000, 8'h04);
    rc(8'h10, 8'h10);
    ev(21'h180075, 8'h00);
    rc(DS, 8'hC7);
    rc(DS, 8'h04);
    rc(CI, 8'h1A);
    rc(DS, 8'h00);
    host.ack();
    chk("pulses", {4'h0, pulseCnt}, 8'h02);
    host.wr(DM, 8'h84);
    ev(21'h080020, 8'h00);
    ci(1'b1);
    rc(DS, 8'h04);
    host.wr(DM, 8'h00);
    ci(1'b0);
    rc(DS, 8'h84);
    rc(CI, 8'h10);
    ci(1'b1);
    fork
      ev(21'h080000, 8'h00);
      rc(DS, 8'h00);
    join
    rc(DS, 8'h80);
    ev(21'h040000, 8'h00);
    rc(TS, 8'h10);
    rc(DX, 8'h10);
    rc(TS, 8'h00);
    ev(21'h020D80, 8'h00);
    rc(DX, 8'h00);
    rc(DS, 8'h00);
    host.wr(MD, 8'h01);
    rc(MD, 8'h01);
    host.wr(TM, 8'h30);
    rc(TM, 8'h30);
    ev(21'h020D80, 8'h00);
    rc(TS, 8'h00);
    ci(1'b1);
    rc(DX, 8'hA0);
    rc(DS, 8'h28);
    host.wr(TM, 8'h00);
    ev(21'h001200, 8'h00);
    rc(DX, 8'h80);
    rc(DS, 8'h08);
    host.wr(DC, 8'h01);
    rc(DS, 8'h10);
    host.wr(DC, 8'h0C);
    ev(21'h018000, 8'h00);
    rc(DS, 8'h00);
    ev(21'h004000, 8'h00);
    rc(DS, 8'h10);
    host.wr(DC, 8'h02);
    ev(21'h010000, 8'h00);
    rc(DS, 8'h10);
    ev(21'h002000, 8'h00);
    rc(DX, 8'h40);
    host.wr(DC, 8'h0A);
    ev(21'h008000, 8'h00);
    rc(DS, 8'h10);
    host.wr(8'h11, 8'h10);
    rc(8'h11, 8'h10);
    host.wr(8'h13, 8'h01);
    ci(1'b1);
    rc(8'h10, 8'h00);
    host.wr(8'h11, 8'h00);
    ci(1'b0);
    rc(8'h10, 8'h10);
    chk("pulses", {4'h0, pulseCnt}, 8'h03);
    results();
  end
endmodule
`default_nettype wire
